// File: rtl/css_map.svh
// Purpose: Offsets, field positions, reset values and timing for the supervisor
// Assumes: 200 MHz clock, Wishbone byte addresses
// Notes:   Definitions only
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
// Clock and times
`define CSS_CLK_PERIOD_NS 5
`define CSS_INT_PULSE_NS  128000
`define CSS_TICK_NS       1000000
// Register byte offsets
`define CSS_OFF_CTRL  8'h00
`define CSS_OFF_INPUT_CURRENT_LIMIT  8'h04
`define CSS_OFF_FAST_CHARGE_CURRENT_SETTING  8'h08
`define CSS_OFF_VREG  8'h0C
`define CSS_OFF_STAT  8'h10
`define CSS_OFF_TMR   8'h14
// Control fields
`define CSS_CTRL_CEN   0
`define CSS_CTRL_SLOW  1
`define CSS_CTRL_TSEL  3:2
`define CSS_CEN_RST    1'h1
`define CSS_SLOW_RST   1'h0
`define CSS_TSEL_RST   2'h1
// Value registers: input_current_limit code n means (n+1) x 50 mA, 50..400 mA
`define CSS_INPUT_CURRENT_LIMIT_RST   3'h1
`define CSS_FAST_CHARGE_CURRENT_SETTING_RST   8'h0A
// Regulation code: 10 mV steps above the 3.6 V floor
`define CSS_VREG_RST   7'h3C
`define CSS_WARM_STEP  7'h0E
// Safety durations in ms ticks, zero disables
`define CSS_TMR0_MS    25'h0293370
`define CSS_TMR1_MS    25'h0A4CB80
`define CSS_TMR2_MS    25'h1499700
`define CSS_TMR3_MS    25'h0000000
`define CSS_PRE_DIV    25'hA
`endif

// File: rtl/css_pkg.sv
// Purpose: Types of the charge-safety supervisor
// Assumes: Nothing
// Notes:   Shared by design and bench
package css_pkg;
  typedef enum logic [1:0] {css_idle, css_charge, css_done, css_fault} css_state_t;
  typedef logic [2:0]  css_input_current_limit_t;
  typedef logic [7:0]  css_fast_charge_current_setting_t;
  typedef logic [6:0]  css_vreg_t;
  typedef logic [24:0] css_ms_t;
endpackage

// File: rtl/css_supervisor.sv
// Purpose: Charge safety timer, thermistor zones, thermal shutdown, limit select
// Assumes: Comparator and pin levels arrive asynchronously
// Notes:   Registers on classic Wishbone, one word each
//
// The register addresses and register access over Wishbone were left to the implementer.
`include "css_map.svh"
`timescale 1ns/100ps
`default_nettype none
module css_supervisor #(
  parameter int TICK_CYC = `CSS_TICK_NS / `CSS_CLK_PERIOD_NS,
  parameter int INT_CYC  = `CSS_INT_PULSE_NS / `CSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // Pins and comparators, asynchronous
  input  wire logic              charge_inhibit_pin_i,
  input  wire logic              vin_valid_i,
  input  wire logic              ts_hot_i,
  input  wire logic              ts_cold_i,
  input  wire logic              ts_cool_i,
  input  wire logic              ts_warm_i,
  input  wire logic              thermistor_off_level_i,
  input  wire logic              die_shutdown_i,
  input  wire logic              die_cooled_i,
  input  wire logic              term_done_i,
  input  wire logic              loop_cc_cv_i,
  input  wire logic              precharge_i,
  input  wire logic              input_current_limit_pin_gnd_i,
  input  wire logic              fast_charge_current_setting_pin_gnd_i,
  input  wire css_pkg::css_input_current_limit_t input_current_limit_pin_code_i,
  input  wire css_pkg::css_fast_charge_current_setting_t fast_charge_current_setting_pin_code_i,
  // Interrupt, open drain
  output logic                   int_o,
  output logic                   int_oe_o,
  // Charger and rail controls
  output logic                   charge_en_o,
  output logic                   mid_supply_en_o,
  output logic                   rail_en_o,
  output logic                   aux_en_o,
  output css_pkg::css_input_current_limit_t     input_current_limit_o,
  output css_pkg::css_fast_charge_current_setting_t     fast_charge_current_setting_o,
  output css_pkg::css_vreg_t     vreg_code_o
);
  import css_pkg::*;

  // Duration of a select code
  function automatic css_ms_t dur_of(input logic [1:0] s);
    unique case (s)
      2'h0: dur_of = `CSS_TMR0_MS;
      2'h1: dur_of = `CSS_TMR1_MS;
      2'h2: dur_of = `CSS_TMR2_MS;
      2'h3: dur_of = `CSS_TMR3_MS;
    endcase
  endfunction

  // Two-stage synchronisers for all pins
  localparam int NS = 25;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sync1_q;          // Read by sync2_q only
  logic [NS-1:0] sync2_q;
  assign pin_raw = {fast_charge_current_setting_pin_code_i, input_current_limit_pin_code_i, fast_charge_current_setting_pin_gnd_i,
                    input_current_limit_pin_gnd_i, precharge_i, loop_cc_cv_i, term_done_i,
                    die_cooled_i, die_shutdown_i, thermistor_off_level_i,
                    ts_warm_i, ts_cool_i, ts_cold_i, ts_hot_i, vin_valid_i,
                    charge_inhibit_pin_i};
  always_ff @(posedge clk_i)
  begin
    sync1_q <= pin_raw;
    sync2_q <= sync1_q;
  end
  // Named synchronised levels
  wire inh_s   = sync2_q[0];
  wire vin_s   = sync2_q[1];
  wire hot_s   = sync2_q[2];
  wire cold_s  = sync2_q[3];
  wire cool_s  = sync2_q[4];
  wire warm_s  = sync2_q[5];
  wire tsoff_s = sync2_q[6];
  wire dhot_s  = sync2_q[7];
  wire dcool_s = sync2_q[8];
  wire term_s  = sync2_q[9];
  wire ccv_s   = sync2_q[10];
  wire pre_s   = sync2_q[11];
  wire ignd_s  = sync2_q[12];
  wire sgnd_s  = sync2_q[13];
  wire css_input_current_limit_t ipin_s = sync2_q[16:14];
  wire css_fast_charge_current_setting_t spin_s = sync2_q[24:17];

  // Software registers
  logic      cen_n_q;              // Active-low charge enable
  logic      slow_q;               // Half-rate timer enable
  logic [1:0] tsel_q;              // Safety time select
  css_input_current_limit_t input_current_limit_q;
  css_fast_charge_current_setting_t fast_charge_current_setting_q;
  css_vreg_t vreg_q;
  logic      host_q;               // Set by first bus write
  logic      ack_q;

  // Bus decode
  wire req     = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_lane = req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = wr_lane & (wb_adr_i == `CSS_OFF_CTRL);
  wire wr_input_current_limit = wr_lane & (wb_adr_i == `CSS_OFF_INPUT_CURRENT_LIMIT);
  wire wr_fast_charge_current_setting = wr_lane & (wb_adr_i == `CSS_OFF_FAST_CHARGE_CURRENT_SETTING);
  wire wr_vreg = wr_lane & (wb_adr_i == `CSS_OFF_VREG);

  // State and timer
  css_state_t st_q, st_d;
  css_ms_t    tmr_q, tmr_d;
  logic [17:0] pre_q;              // Tick prescaler
  logic       half_q;              // Half-rate phase
  logic       fault_q;
  logic       tshut_q;
  logic       inh_prev_q;
  logic       vin_prev_q;
  logic [14:0] int_cnt_q;

  // Zone decode, all void while thermistor is off
  wire ts_susp  = ~tsoff_s & (hot_s | cold_s);
  wire cool_act = ~tsoff_s & ~ts_susp & cool_s;
  wire warm_act = ~tsoff_s & ~ts_susp & warm_s;

  // Charge request; die shutdown withdraws it
  wire charge_req = vin_s & ~inh_s & ~cen_n_q & ~tshut_q;
  wire start      = (st_q == css_idle) & charge_req & ~fault_q;
  wire running    = st_q == css_charge;

  // Prescaled tick and rate choice
  wire tick     = pre_q == 18'(TICK_CYC - 1);
  wire full_rt  = ~slow_q | ccv_s;
  wire run      = running & ~ts_susp;
  wire adv      = run & tick & (full_rt | half_q);
  wire tsel_chg = wr_ctrl & (wb_dat_i[`CSS_CTRL_TSEL] != tsel_q) & running;
  wire tmr_clr  = start | tshut_q | tsel_chg;

  // Limit compare, pre-charge is one tenth
  wire css_ms_t dur   = dur_of(tsel_q);
  wire css_ms_t limit = pre_s ? dur / `CSS_PRE_DIV : dur;
  wire expire = run & ~term_s & (dur != '0) & (tmr_q >= limit);

  // Fault clear events
  wire inh_edge = inh_s ^ inh_prev_q;
  wire vin_fall = vin_prev_q & ~vin_s;

  // Selected limits
  wire css_input_current_limit_t input_current_limit_sel = (host_q | ignd_s) ? input_current_limit_q : ipin_s;
  wire css_fast_charge_current_setting_t fast_charge_current_setting_sel = sgnd_s ? fast_charge_current_setting_q : spin_s;
  wire css_vreg_t vwarm    = (vreg_q > `CSS_WARM_STEP) ? vreg_q - `CSS_WARM_STEP : '0;

  // Next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      css_idle:
        if (start)
          st_d = css_charge;
      css_charge:
        if (!charge_req)
          st_d = css_idle;
        else if (term_s)
          st_d = css_done;
        else if (expire)
          st_d = css_fault;
      css_done:
        if (!charge_req)
          st_d = css_idle;
      css_fault:
        if (!fault_q)
          st_d = css_idle;
    endcase
  end

  // Timer next value: clear beats advance
  always_comb
  begin
    tmr_d = tmr_q;
    if (tmr_clr)
      tmr_d = '0;
    else if (adv)
      tmr_d = tmr_q + 25'h0000001;
  end

  // Register file writes and host mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cen_n_q <= `CSS_CEN_RST;
      slow_q  <= `CSS_SLOW_RST;
      tsel_q  <= `CSS_TSEL_RST;
      input_current_limit_q  <= `CSS_INPUT_CURRENT_LIMIT_RST;
      fast_charge_current_setting_q  <= `CSS_FAST_CHARGE_CURRENT_SETTING_RST;
      vreg_q  <= `CSS_VREG_RST;
      host_q  <= 1'h0;
    end
    else
    begin
      // Any write leaves default mode
      if (req & wb_we_i)
        host_q <= 1'h1;
      if (wr_ctrl)
      begin
        cen_n_q <= wb_dat_i[`CSS_CTRL_CEN];
        slow_q  <= wb_dat_i[`CSS_CTRL_SLOW];
        tsel_q  <= wb_dat_i[`CSS_CTRL_TSEL];
      end
      if (wr_input_current_limit)
        input_current_limit_q <= wb_dat_i[2:0];
      if (wr_fast_charge_current_setting)
        fast_charge_current_setting_q <= wb_dat_i[7:0];
      if (wr_vreg)
        vreg_q <= wb_dat_i[6:0];
    end
  end

  // Bus answer: one wait state, unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q    <= 1'h0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      ack_q <= req;
      unique case (wb_adr_i)
        `CSS_OFF_CTRL: wb_dat_o <= {28'h0, tsel_q, slow_q, cen_n_q};
        `CSS_OFF_INPUT_CURRENT_LIMIT: wb_dat_o <= {29'h0, input_current_limit_q};
        `CSS_OFF_FAST_CHARGE_CURRENT_SETTING: wb_dat_o <= {24'h0, fast_charge_current_setting_q};
        `CSS_OFF_VREG: wb_dat_o <= {25'h0, vreg_q};
        `CSS_OFF_STAT: wb_dat_o <= {26'h0, host_q, ts_susp, tshut_q, fault_q, st_q};
        `CSS_OFF_TMR:  wb_dat_o <= {7'h0, tmr_q};
        default:       wb_dat_o <= 32'h00000000;
      endcase
    end
  end
  assign wb_ack_o = ack_q;

  // Timer, prescaler, fault and shutdown latches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q       <= css_idle;
      tmr_q      <= '0;
      pre_q      <= 18'h00000;
      half_q     <= 1'h0;
      fault_q    <= 1'h0;
      tshut_q    <= 1'h0;
      inh_prev_q <= 1'h0;
      vin_prev_q <= 1'h0;
    end
    else
    begin
      st_q       <= st_d;
      tmr_q      <= tmr_d;
      inh_prev_q <= inh_s;
      vin_prev_q <= vin_s;
      // Prescaler freezes with the timer
      if (tmr_clr)
      begin
        pre_q  <= 18'h00000;
        half_q <= 1'h0;
      end
      else if (run)
      begin
        pre_q <= tick ? 18'h00000 : pre_q + 18'h00001;
        if (tick)
          half_q <= ~half_q;
      end
      // Set wins over the clear
      if (expire)
        fault_q <= 1'h1;
      else if (inh_edge | vin_fall)
        fault_q <= 1'h0;
      // Hysteresis: leave only once cooled
      if (dhot_s)
        tshut_q <= 1'h1;
      else if (dcool_s)
        tshut_q <= 1'h0;
    end
  end

  // Interrupt pulse timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      int_cnt_q <= 15'h0000;
    else if (expire & ~fault_q)
      int_cnt_q <= 15'(INT_CYC);
    else if (int_cnt_q != 15'h0000)
      int_cnt_q <= int_cnt_q - 15'h0001;
  end
  assign int_o    = 1'b0;
  assign int_oe_o = int_cnt_q != 15'h0000;

  // Outputs to the analog side
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_en_o                   <= 1'h0;
      mid_supply_en_o               <= 1'h0;
      rail_en_o                     <= 1'h0;
      aux_en_o                      <= 1'h0;
      input_current_limit_o         <= `CSS_INPUT_CURRENT_LIMIT_RST;
      fast_charge_current_setting_o <= `CSS_FAST_CHARGE_CURRENT_SETTING_RST;
      vreg_code_o                   <= `CSS_VREG_RST;
    end
    else
    begin
      charge_en_o     <= (st_d == css_charge) & ~ts_susp & ~tshut_q;
      mid_supply_en_o <= ~tshut_q;
      rail_en_o       <= ~tshut_q;
      aux_en_o        <= ~tshut_q;
      input_current_limit_o <= input_current_limit_sel;
      // Code assumed linear in current, so a shift halves it
      fast_charge_current_setting_o <= cool_act ? fast_charge_current_setting_sel >> 1 : fast_charge_current_setting_sel;
      // Code zero is the floor, so no wrap below it
      vreg_code_o <= warm_act ? vwarm : vreg_q;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_start;
    start |=> tmr_q == '0 && st_q == css_charge;
  endproperty
  a_start: assert property (p_start) else $error("timer not cleared at start");

  property p_expire;
    expire |=> fault_q && st_q == css_fault ##1 !charge_en_o;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry did not fault");

  property p_pre;
    run && pre_s && !term_s && dur != '0 && tmr_q >= dur / `CSS_PRE_DIV |=> fault_q;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge limit missed");

  property p_int;
    $rose(int_oe_o) |-> int_cnt_q == 15'(INT_CYC) && $past(expire) && fault_q;
  endproperty
  a_int: assert property (p_int) else $error("interrupt pulse wrong");

  property p_hold;
    fault_q && !inh_edge && !vin_fall |=> fault_q;
  endproperty
  a_hold: assert property (p_hold) else $error("fault cleared early");

  property p_tsel;
    tsel_chg |=> tmr_q == '0;
  endproperty
  a_tsel: assert property (p_tsel) else $error("duration change no restart");

  property p_susp;
    ts_susp && !tmr_clr |=> $stable(tmr_q) && !charge_en_o;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend not honoured");

  property p_cool;
    cool_act |=> fast_charge_current_setting_o == ($past(fast_charge_current_setting_sel) >> 1);
  endproperty
  a_cool: assert property (p_cool) else $error("cool current not halved");

  property p_shut;
    tshut_q |=> tmr_q == '0 && !mid_supply_en_o && !rail_en_o && !charge_en_o;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown actions missing");

  c_fault: cover property (expire ##1 fault_q);
  c_done:  cover property (running && term_s ##1 st_q == css_done);
  c_shut:  cover property (running && tshut_q ##1 st_q == css_idle);
endmodule
`default_nettype wire

// File: testbench/css_env_model.sv
// Purpose: Thermistor divider and die sensor that face the supervisor
// Assumes: Bench sets sense voltage and die temperature as 8-bit codes
// Notes:   Comparator levels change only just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module css_env_model #(
  parameter logic [7:0] HOT_V   = 8'h28, // Low voltage means a hot pack
  parameter logic [7:0] WARM_V  = 8'h50, // Top of the warm zone
  parameter logic [7:0] COOL_V  = 8'hA0, // Bottom of the cool zone
  parameter logic [7:0] COLD_V  = 8'hC8, // Above this the pack is cold
  parameter logic [7:0] OFF_V   = 8'hF0, // Sense pulled up, zones unused
  parameter logic [7:0] DIE_LIM = 8'h7D, // Die shutdown limit
  parameter logic [7:0] DIE_HYS = 8'h14  // Cooling margin before restart
) (
  // Clock
  input  wire logic       clk_i,
  // Conditions set by the bench
  input  wire logic [7:0] ts_volt_i,
  input  wire logic [7:0] die_temp_i,
  // Comparator levels
  output logic            ts_hot_o,
  output logic            ts_cold_o,
  output logic            ts_cool_o,
  output logic            ts_warm_o,
  output logic            thermistor_off_level_o,
  output logic            die_hot_o,
  output logic            die_cool_o
);
  // Comparators, registered so no level moves on the sampling edge
  always_ff @(posedge clk_i)
  begin
    ts_hot_o   <= ts_volt_i < HOT_V;
    ts_warm_o  <= ts_volt_i >= HOT_V && ts_volt_i < WARM_V;
    ts_cool_o  <= ts_volt_i > COOL_V && ts_volt_i <= COLD_V;
    // A pulled-up divider also trips cold, so the off level must win
    ts_cold_o  <= ts_volt_i > COLD_V;
    thermistor_off_level_o   <= ts_volt_i >= OFF_V;
    die_hot_o  <= die_temp_i >= DIE_LIM;
    // Cooled only once the full margin is reached, never at the limit
    die_cool_o <= die_temp_i <= DIE_LIM - DIE_HYS;
  end
endmodule
`default_nettype wire

// File: testbench/test_css_supervisor.sv
// Purpose: Self-checking bench for the charge-safety supervisor
// Assumes: Short tick and pulse counts so timer rates show quickly
// Notes:   Full safety durations outlast the run; expiry is left to the design checks
`timescale 1ns/100ps
`default_nettype none
module test_css_supervisor;
  import css_pkg::*;
  localparam int TICK = 4; // Cycles per timer tick
  // Bench-driven inputs
  logic        clk_i, rst_i, cyc, stb, we, inh, vin, term, cccv, igd, sgd, pre;
  logic [7:0]  adr, ts_v, die_t;
  logic [3:0]  sel;
  logic [31:0] wdat, q;
  css_input_current_limit_t   ipin;
  css_fast_charge_current_setting_t   spin;
  // Observed outputs and model levels
  logic [31:0] dout;
  logic        ack, int_od, int_oe, chg, mid, rail, aux;
  logic        hot, cold, cool, warm, off, dsh, dcl;
  css_input_current_limit_t   input_current_limit;
  css_fast_charge_current_setting_t   fast_charge_current_setting;
  css_vreg_t   vreg;
  int          errors, compares, cyc_cnt;
  // Reset read table, last entry unmapped
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
  logic [31:0] rv [5] = '{32'h5, 32'h1, 32'h0A, 32'h3C, 32'h0};
  // Sense voltages: nominal, cool, warm, hot, cold, off
  logic [7:0]  tv [6] = '{8'h78, 8'hB4, 8'h3C, 8'h14, 8'hDC, 8'hFA};
  css_fast_charge_current_setting_t   s;
  css_vreg_t   r;
  // Open-drain interrupt line with pull-up
  wire         int_n = int_oe ? 1'b0 : 1'b1;

  css_supervisor #(.TICK_CYC(TICK), .INT_CYC(8)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .charge_inhibit_pin_i(inh), .vin_valid_i(vin), .ts_hot_i(hot), .ts_cold_i(cold),
    .ts_cool_i(cool), .ts_warm_i(warm), .thermistor_off_level_i(off), .die_shutdown_i(dsh),
    .die_cooled_i(dcl), .term_done_i(term), .loop_cc_cv_i(cccv), .precharge_i(pre),
    .input_current_limit_pin_gnd_i(igd), .fast_charge_current_setting_pin_gnd_i(sgd), .input_current_limit_pin_code_i(ipin), .fast_charge_current_setting_pin_code_i(spin),
    .int_o(int_od), .int_oe_o(int_oe), .charge_en_o(chg), .mid_supply_en_o(mid),
    .rail_en_o(rail), .aux_en_o(aux), .input_current_limit_o(input_current_limit),
    .fast_charge_current_setting_o(fast_charge_current_setting), .vreg_code_o(vreg));

  css_env_model i_env (
    .clk_i(clk_i), .ts_volt_i(ts_v), .die_temp_i(die_t), .ts_hot_o(hot), .ts_cold_o(cold),
    .ts_cool_o(cool), .ts_warm_o(warm), .thermistor_off_level_o(off), .die_hot_o(dsh), .die_cool_o(dcl));

  // Clock, 5 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      errors++;
      print_verdict;
    end
  end

  task automatic print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One classic cycle; holds everything until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= m;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Pins pass two sync flops and a register
  task automatic settle;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_chg(input logic v);
    for (int n = 0; n < 40 && chg !== v; n++)
    begin
      @(posedge clk_i);
      #1;
    end
    chk("charge_en", 32'(chg), 32'(v));
  endtask

  // Two timer reads whose captures lie exactly ten ticks apart
  task automatic rate(input logic [31:0] e);
    logic [31:0] a;
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    a = q;
    repeat (10 * TICK - 3) @(posedge clk_i);
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk("timer_delta", q - a, e);
  endtask

  // Warm zone target: 140 mV down in 10 mV codes, floor at code 0
  function automatic css_vreg_t exp_vreg(input css_vreg_t v);
    return (v >= 7'h0E) ? v - 7'h0E : 7'h00;
  endfunction

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  initial
  begin
    void'($urandom(32'h55440EF4));
    {cyc, stb, we, inh, vin, term, cccv, pre} = '0;
    {igd, sgd} = 2'b11;
    {adr, wdat, sel} = '0;
    ts_v = 8'h78;
    die_t = 8'h32;
    ipin = 3'($urandom_range(7, 2));
    spin = 8'($urandom_range(255, 16));
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b0, ra[i], 32'h0, 4'hF);
      chk("reset_read", q, rv[i]);
    end
    // Resistor codes used until a pin is grounded
    @(posedge clk_i);
    {igd, sgd} <= 2'b00;
    settle;
    chk("input_current_limit_pin", 32'(input_current_limit), 32'(ipin));
    chk("fast_charge_current_setting_pin", 32'(fast_charge_current_setting), 32'(spin));
    @(posedge clk_i);
    {igd, sgd} <= 2'b11;
    settle;
    chk("input_current_limit_gnd", 32'(input_current_limit), 32'h1);
    chk("fast_charge_current_setting_gnd", 32'(fast_charge_current_setting), 32'h0A);
    @(posedge clk_i);
    igd <= 1'b0;
    // Host mode: every limit code, upper bits discarded, pin ignored
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h04, {29'($urandom), 3'(i)}, 4'hF);
      wb(1'b0, 8'h04, 32'h0, 4'hF);
      chk("input_current_limit_reg", q, 32'(i));
      settle;
      chk("input_current_limit_out", 32'(input_current_limit), 32'(i));
    end
    wb(1'b1, 8'h04, 32'h5, 4'h0);
    wb(1'b0, 8'h04, 32'h0, 4'hF);
    chk("input_current_limit_nosel", q, 32'h7);
    done("limits");
    // Start a charge cycle from the host
    @(posedge clk_i);
    vin <= 1'b1;
    wb(1'b1, 8'h00, 32'h0, 4'hF);
    wait_chg(1'b1);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk("stat_charge", q & 32'h23, 32'h21);
    chk("rails_on", 32'({mid, rail, aux}), 32'h7);
    // Timer rates: full, full with slow set under CC/CV, slow outside CC/CV
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, 8'h00, {30'h0, i > 0, 1'b0}, 4'hF);
      @(posedge clk_i);
      cccv <= (i == 1);
      // Pre-charge only shortens the limit, the rate is unchanged
      pre  <= (i == 1);
      settle;
      rate((i == 2) ? 32'h5 : 32'hA);
    end
    @(posedge clk_i);
    cccv <= 1'b1;
    pre  <= 1'b0;
    // New duration while running restarts the count
    wb(1'b1, 8'h00, 32'h4, 4'hF);
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk("timer_restart", 32'(q < 2), 32'h1);
    done("timer");
    // Every thermistor zone, random settings then floor corner
    for (int k = 0; k < 2; k++)
    begin
      s = 8'($urandom);
      r = (k == 1) ? 7'h0D : 7'($urandom_range(127, 14));
      wb(1'b1, 8'h08, 32'(s), 4'hF);
      wb(1'b1, 8'h0C, 32'(r), 4'hF);
      for (int z = 0; z < 6; z++)
      begin
        @(posedge clk_i);
        ts_v <= tv[z];
        settle;
        chk("charge_zone", 32'(chg), 32'(z < 3 || z == 5));
        chk("fast_charge_current_setting_zone", 32'(fast_charge_current_setting), 32'((z == 1) ? s >> 1 : s));
        chk("vreg_zone", 32'(vreg), 32'((z == 2) ? exp_vreg(r) : r));
        rate((z == 3 || z == 4) ? 32'h0 : 32'hA);
      end
    end
    done("thermistor");
    // Die shutdown, partial cooling, then full cooling
    @(posedge clk_i);
    die_t <= 8'h96;
    settle;
    chk("die_stop", 32'({chg, mid, rail, aux}), 32'h0);
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk("die_timer", q, 32'h0);
    @(posedge clk_i);
    die_t <= 8'h6E;
    settle;
    chk("die_hys", 32'(chg), 32'h0);
    @(posedge clk_i);
    die_t <= 8'h5A;
    wait_chg(1'b1);
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk("die_restart", 32'(q < 4), 32'h1);
    chk("rails_back", 32'({mid, rail, aux}), 32'h7);
    done("die");
    // Inhibit toggle as a recovering host would, then termination
    @(posedge clk_i);
    inh <= 1'b1;
    wait_chg(1'b0);
    @(posedge clk_i);
    inh <= 1'b0;
    wait_chg(1'b1);
    @(posedge clk_i);
    term <= 1'b1;
    wait_chg(1'b0);
    wb(1'b0, 8'h10, 32'h0, 4'hF);
    chk("stat_done", q & 32'h3, 32'h2);
    chk("int_idle", 32'(int_n), 32'h1);
    chk("int_drive", 32'(int_od), 32'h0);
    done("inhibit");
    print_verdict;
  end
endmodule
`default_nettype wire
